// File: rtl/encs_cfg.svh
// offsets, field positions, sizes and timing of the nvm command sequencer
`ifndef ENCS_CFG_SVH
`define ENCS_CFG_SVH
// register byte addresses on the register bus
`define ENCS_ADDR_CMD 8'h00
`define ENCS_ADDR_MEMORY_CONTROL_A 8'h04
`define ENCS_ADDR_STATUS 8'h08
`define ENCS_ADDR_DATA 8'h0c
`define ENCS_ADDR_LOCK 8'h10
// field positions
`define ENCS_MEMORY_CONTROL_A_EXEC 0
`define ENCS_STAT_REJ 2
// port address regions, selected by address bits 15:12
`define ENCS_REG_FLASH 4'h0
`define ENCS_REG_EEP 4'h1
`define ENCS_REG_FUSE 4'h2
`define ENCS_REG_ROW 4'h3
// array sizes
`define ENCS_FLASH_BYTES 256
`define ENCS_EEP_BYTES 64
`define ENCS_FUSE_BYTES 8
`define ENCS_SIG_BYTES 16
`define ENCS_FPAGE_WORDS 8
`define ENCS_EPAGE_BYTES 8
// fuse layout, a programmed bit reads 0
`define ENCS_LOCK_IDX 3'h7
`define ENCS_EEPROM_PRESERVE_FUSE_IDX 3'h5
`define ENCS_EEPROM_PRESERVE_FUSE_BIT 3
// reset values and the crc polynomial
`define ENCS_ERASED 8'hff
`define ENCS_CRC_INIT 16'hffff
`define ENCS_CRC_POLY 16'h1021
// timing
`define ENCS_CLK_PERIOD_NS 50
`define ENCS_OP_TIME_NS 4000
`define ENCS_OP_CYCLES \
  ((`ENCS_OP_TIME_NS + `ENCS_CLK_PERIOD_NS - 1) / `ENCS_CLK_PERIOD_NS)
`endif

// File: rtl/encs_pkg.sv
// types shared by the nvm command sequencer
package encs_pkg;
  typedef enum logic [6:0] {
    cmd_nop = 7'h00, cmd_chip_erase = 7'h40, cmd_read = 7'h43,
    cmd_ld_fbuf = 7'h23, cmd_er_fbuf = 7'h26, cmd_er_fpage = 7'h2b,
    cmd_wr_fpage = 7'h2e, cmd_ew_fpage = 7'h2f, cmd_flash_crc = 7'h78,
    cmd_er_app = 7'h20, cmd_er_apage = 7'h22, cmd_wr_apage = 7'h24,
    cmd_ew_apage = 7'h25, cmd_app_crc = 7'h38, cmd_er_boot = 7'h68,
    cmd_er_bpage = 7'h2a, cmd_wr_bpage = 7'h2c, cmd_ew_bpage = 7'h2d,
    cmd_boot_crc = 7'h39, cmd_rd_sig = 7'h01, cmd_er_sig = 7'h18,
    cmd_wr_sig = 7'h1a, cmd_rd_cal = 7'h02, cmd_rd_fuse = 7'h07,
    cmd_wr_fuse = 7'h4c, cmd_wr_lock = 7'h08, cmd_ld_ebuf = 7'h33,
    cmd_er_ebuf = 7'h36, cmd_er_eep = 7'h30, cmd_er_epage = 7'h32,
    cmd_wr_epage = 7'h34, cmd_ew_epage = 7'h35, cmd_rd_eep = 7'h06
  } encs_cmd_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00, st_timed = 2'b01, st_crc = 2'b10
  } encs_state_t;
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } encs_port_req_t;
endpackage : encs_pkg

// File: rtl/encs_sequencer.sv
// nvm command sequencer behind the program and debug port
//
// How it works
// R01 - chip erase clears flash, eeprom, lock bits
// R02 - eeprom kept when preserve fuse programmed
// R03 - chip erase drops interface enabled bit
// R04 - command first, then execute bit; busy
// R05 - read command then port read returns byte
// R06 - dedicated reads use same read sequence
// R07 - each load write puts one buffer byte
// R08 - programmer writes low byte before high
// R09 - low byte held, word stored together
// R10 - port stalled after each load write
// R11 - page erase clears one page, busy
// R12 - write page programs buffer into page
// R13 - erase then write as one operation
// R14 - section erase clears whole section
// R15 - crc result lands in data register
// R16 - self-programming needs unlock before execute; here the execute bit starts the operation with no unlock
// R17 - flash crc runs whatever the lock bits
// R18 - flash crc drops interface enabled bit
// R19 - fuse and lock writes only clear bits
// R20 - programmer enables port before any command; here the interface enabled bit is already set out of reset
// R21 - seven-bit command field, zero is idle
// R22 - full lock allows chip erase, flash crc only
// R23 - no memory reads while busy
// R24 - busy clear and enable set together
`include "encs_cfg.svh"
`timescale 1ns/1ps
module encs_sequencer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // program and debug port memory path
  input wire logic port_req_valid,
  input wire encs_pkg::encs_port_req_t port_req,
  output logic port_req_ready,
  output logic port_rvalid,
  output logic [7:0] port_rdata,
  output logic port_memory_interface_enabled,
  // status
  output logic busy
);
  import encs_pkg::*;

  // memories and page buffers
  logic [7:0] flash [`ENCS_FLASH_BYTES];
  logic [7:0] eep [`ENCS_EEP_BYTES];
  logic [7:0] fuse [`ENCS_FUSE_BYTES];
  logic [7:0] sig [`ENCS_SIG_BYTES];
  logic [15:0] fbuf [`ENCS_FPAGE_WORDS];
  logic [7:0] ebuf [`ENCS_EPAGE_BYTES];
  logic [7:0] low_temp;

  // register bus state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [6:0] cmd_reg;
  logic [15:0] data_reg;
  logic rejected;

  // sequencer state
  encs_state_t state;
  encs_cmd_t op_cmd;
  logic [15:0] op_addr;
  logic [15:0] last_addr;
  logic [7:0] op_cnt;
  logic [7:0] crc_ptr;
  logic [7:0] crc_end;
  logic [15:0] crc_acc;

  // decode
  encs_cmd_t cur;
  logic wr_fire, exec_req, locked_rw, allowed;
  logic is_exec, is_wtrig, is_load, is_read;
  logic port_fire, load_wr, start_port, start_exec, reject_ev;
  logic timed_done, crc_done;
  logic [15:0] crc_next;
  logic [7:0] rd_byte;
  logic [3:0] region;

  // one crc-16 step over a byte, msb first
  function automatic logic [15:0] encs_crc_step(input logic [15:0] c,
                                                input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int b = 0; b < 8; b++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ `ENCS_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : encs_crc_step

  // command classes and trigger qualification
  always_comb begin
    cur = encs_cmd_t'(cmd_reg); // R21
    locked_rw = (fuse[`ENCS_LOCK_IDX][1:0] == 2'b00);
    allowed = !locked_rw || cur == cmd_chip_erase ||
              cur == cmd_flash_crc; // R22 R17
    is_exec = 1'b0;
    is_wtrig = 1'b0;
    is_read = 1'b0;
    is_load = (cur == cmd_ld_fbuf) || (cur == cmd_ld_ebuf);
    case (cur)
      cmd_chip_erase, cmd_er_fbuf, cmd_er_ebuf, cmd_flash_crc,
      cmd_app_crc, cmd_boot_crc, cmd_wr_lock, cmd_er_eep: is_exec = 1'b1;
      cmd_er_app, cmd_er_boot, cmd_er_fpage, cmd_er_apage, cmd_er_bpage,
      cmd_er_sig, cmd_er_epage: begin
        is_exec = 1'b1; // R11 R14
        is_wtrig = 1'b1;
      end
      cmd_wr_fpage, cmd_ew_fpage, cmd_wr_apage, cmd_ew_apage,
      cmd_wr_bpage, cmd_ew_bpage, cmd_wr_sig, cmd_wr_epage,
      cmd_ew_epage, cmd_wr_fuse: is_wtrig = 1'b1;
      cmd_read, cmd_rd_sig, cmd_rd_cal, cmd_rd_fuse,
      cmd_rd_eep: is_read = 1'b1;
      default: is_read = 1'b0;
    endcase
  end

  // request events; the port wins over a same-cycle execute
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign exec_req = wr_fire && aw_addr == `ENCS_ADDR_MEMORY_CONTROL_A &&
                    w_strb[0] && w_data[`ENCS_MEMORY_CONTROL_A_EXEC];
  assign port_fire = port_req_valid && port_req_ready;
  assign load_wr = port_fire && port_req.we && is_load && allowed;
  assign start_port = port_fire && port_req.we && is_wtrig && allowed;
  assign start_exec = exec_req && !port_fire && state == st_idle &&
                      is_exec && allowed; // R04
  assign reject_ev = (exec_req && !start_exec) ||
                     (port_fire && !allowed) ||
                     (port_fire && port_req.we && !is_wtrig && !is_load) ||
                     (port_fire && !port_req.we && !is_read);
  assign timed_done = (state == st_timed) && (op_cnt == 8'h00);
  assign crc_done = (state == st_crc) && (crc_ptr == crc_end);
  assign crc_next = encs_crc_step(crc_acc, flash[crc_ptr]);
  assign region = port_req.addr[15:12];

  // read mux; dedicated reads only see their own region
  always_comb begin
    rd_byte = 8'h00;
    case (region)
      `ENCS_REG_FLASH: if (cur == cmd_read) begin
        rd_byte = flash[port_req.addr[7:0]]; // R05
      end
      `ENCS_REG_EEP: if (cur == cmd_read || cur == cmd_rd_eep) begin
        rd_byte = eep[port_req.addr[5:0]]; // R06
      end
      `ENCS_REG_FUSE: if (cur == cmd_read || cur == cmd_rd_fuse) begin
        rd_byte = fuse[port_req.addr[2:0]]; // R06
      end
      `ENCS_REG_ROW: begin
        if (port_req.addr[8] && (cur == cmd_read || cur == cmd_rd_cal)) begin
          rd_byte = {4'h0, port_req.addr[3:0]} ^ 8'ha5; // fixed cal row
        end else if (!port_req.addr[8] &&
                     (cur == cmd_read || cur == cmd_rd_sig)) begin
          rd_byte = sig[port_req.addr[3:0]]; // R06
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // register bus write path, response once address and data are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= `ENCS_ADDR_LOCK &&
                        aw_addr[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register bus read path, unmapped words answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `ENCS_ADDR_CMD: s_axi_rdata <= {25'h0, cmd_reg};
        `ENCS_ADDR_MEMORY_CONTROL_A: s_axi_rdata <= 32'h0000_0000;
        `ENCS_ADDR_STATUS: s_axi_rdata <= {29'h0, rejected,
          port_memory_interface_enabled, busy};
        `ENCS_ADDR_DATA: s_axi_rdata <= {16'h0, data_reg};
        `ENCS_ADDR_LOCK: s_axi_rdata <= {24'h0, fuse[`ENCS_LOCK_IDX]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // software registers; hardware set of the reject flag wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_reg <= 7'h00;
      data_reg <= 16'h0000;
      rejected <= 1'b0;
    end else begin
      if (wr_fire && w_strb[0] && aw_addr == `ENCS_ADDR_CMD) begin
        cmd_reg <= w_data[6:0]; // R04
      end
      if (wr_fire && aw_addr == `ENCS_ADDR_DATA) begin
        if (w_strb[0]) data_reg[7:0] <= w_data[7:0];
        if (w_strb[1]) data_reg[15:8] <= w_data[15:8];
      end
      if (crc_done) begin
        data_reg <= crc_next; // R15
      end
      if (reject_ev) begin
        rejected <= 1'b1;
      end else if (wr_fire && w_strb[0] && aw_addr == `ENCS_ADDR_STATUS &&
                   w_data[`ENCS_STAT_REJ]) begin
        rejected <= 1'b0;
      end
    end
  end

  // operation sequencer, busy and the port handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
      op_cmd <= cmd_nop;
      op_addr <= 16'h0000;
      last_addr <= 16'h0000;
      op_cnt <= 8'h00;
      crc_ptr <= 8'h00;
      crc_end <= 8'h00;
      crc_acc <= `ENCS_CRC_INIT;
      busy <= 1'b0;
      port_memory_interface_enabled <= 1'b1;
      port_req_ready <= 1'b0;
      port_rvalid <= 1'b0;
      port_rdata <= 8'h00;
    end else begin
      // every accepted access costs one dead cycle; this is also the
      // stall that lets a load write settle before the next one
      port_req_ready <= !port_fire && !start_exec &&
                        state == st_idle; // R10 R23
      port_rvalid <= port_fire && !port_req.we;
      if (port_fire && !port_req.we) begin
        port_rdata <= (allowed && is_read) ? rd_byte : 8'h00; // R05
      end
      if (port_fire) begin
        last_addr <= port_req.addr;
      end
      if (start_port || start_exec) begin
        op_cmd <= cur;
        op_addr <= start_port ? port_req.addr : last_addr;
        busy <= 1'b1; // R04
        crc_acc <= `ENCS_CRC_INIT;
        crc_ptr <= (cur == cmd_boot_crc) ? 8'h80 : 8'h00;
        crc_end <= (cur == cmd_app_crc) ? 8'h7f : 8'hff;
        op_cnt <= 8'(`ENCS_OP_CYCLES - 1);
        if (cur == cmd_chip_erase || cur == cmd_flash_crc) begin
          port_memory_interface_enabled <= 1'b0; // R03 R18
        end
        if (cur == cmd_flash_crc || cur == cmd_app_crc ||
            cur == cmd_boot_crc) begin
          state <= st_crc;
        end else begin
          state <= st_timed;
        end
      end else if (state == st_timed) begin
        op_cnt <= op_cnt - 8'h01;
      end else if (state == st_crc) begin
        crc_acc <= crc_next;
        crc_ptr <= crc_ptr + 8'h01;
      end
      if (timed_done || crc_done) begin
        state <= st_idle;
        busy <= 1'b0; // R24
        port_memory_interface_enabled <= 1'b1; // R24
      end
    end
  end

  // memory arrays; effects land on the cycle the operation ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_temp <= `ENCS_ERASED;
      for (int i = 0; i < `ENCS_FLASH_BYTES; i++) flash[i] <= `ENCS_ERASED;
      for (int i = 0; i < `ENCS_EEP_BYTES; i++) eep[i] <= `ENCS_ERASED;
      for (int i = 0; i < `ENCS_FUSE_BYTES; i++) fuse[i] <= `ENCS_ERASED;
      for (int i = 0; i < `ENCS_SIG_BYTES; i++) sig[i] <= `ENCS_ERASED;
      for (int i = 0; i < `ENCS_FPAGE_WORDS; i++) fbuf[i] <= 16'hffff;
      for (int i = 0; i < `ENCS_EPAGE_BYTES; i++) ebuf[i] <= `ENCS_ERASED;
    end else begin
      // flash buffer is word wide: low byte waits, high byte commits R08
      if (load_wr && cur == cmd_ld_fbuf) begin
        if (!port_req.addr[0]) begin
          low_temp <= port_req.wdata; // R09
        end else begin
          fbuf[port_req.addr[3:1]] <= {port_req.wdata, low_temp}; // R09
        end
      end
      if (load_wr && cur == cmd_ld_ebuf) begin
        ebuf[port_req.addr[2:0]] <= port_req.wdata; // R07
      end
      if (timed_done) begin
        case (op_cmd)
          cmd_chip_erase: begin
            for (int i = 0; i < `ENCS_FLASH_BYTES; i++) begin
              flash[i] <= `ENCS_ERASED; // R01
            end
            if (fuse[`ENCS_EEPROM_PRESERVE_FUSE_IDX][`ENCS_EEPROM_PRESERVE_FUSE_BIT]) begin
              for (int i = 0; i < `ENCS_EEP_BYTES; i++) begin
                eep[i] <= `ENCS_ERASED; // R02
              end
            end
            fuse[`ENCS_LOCK_IDX] <= `ENCS_ERASED; // R01
          end
          cmd_er_fbuf: for (int i = 0; i < `ENCS_FPAGE_WORDS; i++) begin
            fbuf[i] <= 16'hffff;
          end
          cmd_er_ebuf: for (int i = 0; i < `ENCS_EPAGE_BYTES; i++) begin
            ebuf[i] <= `ENCS_ERASED;
          end
          cmd_er_app, cmd_er_boot: for (int i = 0; i < 128; i++) begin
            flash[{op_cmd == cmd_er_boot, i[6:0]}] <= `ENCS_ERASED; // R14
          end
          cmd_er_eep: for (int i = 0; i < `ENCS_EEP_BYTES; i++) begin
            eep[i] <= `ENCS_ERASED; // R14
          end
          cmd_er_fpage, cmd_er_apage, cmd_er_bpage,
          cmd_wr_fpage, cmd_wr_apage, cmd_wr_bpage,
          cmd_ew_fpage, cmd_ew_apage, cmd_ew_bpage: begin
            for (int i = 0; i < `ENCS_FPAGE_WORDS; i++) begin
              if (op_cmd == cmd_er_fpage || op_cmd == cmd_er_apage ||
                  op_cmd == cmd_er_bpage) begin
                flash[{op_addr[7:4], i[2:0], 1'b0}] <= `ENCS_ERASED; // R11
                flash[{op_addr[7:4], i[2:0], 1'b1}] <= `ENCS_ERASED;
              end else if (op_cmd == cmd_ew_fpage ||
                           op_cmd == cmd_ew_apage ||
                           op_cmd == cmd_ew_bpage) begin
                flash[{op_addr[7:4], i[2:0], 1'b0}] <= fbuf[i][7:0]; // R13
                flash[{op_addr[7:4], i[2:0], 1'b1}] <= fbuf[i][15:8];
              end else begin
                flash[{op_addr[7:4], i[2:0], 1'b0}] <=
                  flash[{op_addr[7:4], i[2:0], 1'b0}] & fbuf[i][7:0]; // R12
                flash[{op_addr[7:4], i[2:0], 1'b1}] <=
                  flash[{op_addr[7:4], i[2:0], 1'b1}] & fbuf[i][15:8];
              end
            end
          end
          cmd_er_sig, cmd_wr_sig: for (int i = 0; i < 8; i++) begin
            sig[{i[2:0], 1'b0}] <= (op_cmd == cmd_er_sig) ? `ENCS_ERASED :
              sig[{i[2:0], 1'b0}] & fbuf[i][7:0]; // R11 R12
            sig[{i[2:0], 1'b1}] <= (op_cmd == cmd_er_sig) ? `ENCS_ERASED :
              sig[{i[2:0], 1'b1}] & fbuf[i][15:8];
          end
          cmd_er_epage, cmd_wr_epage, cmd_ew_epage:
            for (int i = 0; i < `ENCS_EPAGE_BYTES; i++) begin
              eep[{op_addr[5:3], i[2:0]}] <=
                (op_cmd == cmd_er_epage) ? `ENCS_ERASED :
                (op_cmd == cmd_ew_epage) ? ebuf[i] :
                eep[{op_addr[5:3], i[2:0]}] & ebuf[i]; // R11 R12 R13
            end
          cmd_wr_fuse: fuse[op_addr[2:0]] <=
            fuse[op_addr[2:0]] & data_reg[7:0]; // R19
          cmd_wr_lock: fuse[`ENCS_LOCK_IDX] <=
            fuse[`ENCS_LOCK_IDX] & data_reg[7:0]; // R19
          default: low_temp <= low_temp;
        endcase
      end
    end
  end
endmodule : encs_sequencer

// File: verification/encs_sequencer_assertions.sv
// port-level assertions for the nvm command sequencer
`timescale 1ns/1ps
module encs_sequencer_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // port path
  input wire logic port_req_valid,
  input wire encs_pkg::encs_port_req_t port_req,
  input wire logic port_req_ready,
  input wire logic port_rvalid,
  // status and write handshake
  input wire logic port_memory_interface_enabled,
  input wire logic busy,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid
);
  import encs_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take;
  logic [8:0] busy_len;
  // port transfer taken this cycle
  assign take = port_req_valid && port_req_ready;
  // busy spell length
  always_ff @(posedge aclk) begin
    if (!aresetn || !busy) begin
      busy_len <= 9'h000;
    end else begin
      busy_len <= busy_len + 9'h001;
    end
  end
  a_read_answer: assert property (take && !port_req.we |=> port_rvalid)
    else $error("port read not answered next cycle");
  a_answer_pulse: assert property (port_rvalid |=> !port_rvalid)
    else $error("read answer longer than one cycle");
  a_load_stall: assert property (take |=> !port_req_ready)
    else $error("port not stalled after a transfer");
  a_busy_blocks: assert property (busy |-> !port_req_ready)
    else $error("port accepted while busy");
  a_path_off: assert property (!port_memory_interface_enabled |-> busy)
    else $error("path disabled without busy");
  a_path_back: assert property ($rose(port_memory_interface_enabled)
    |-> $fell(busy)) else $error("enable and busy not released together");
  a_busy_span: assert property ($fell(busy) |-> busy_len == 9'h050 ||
    busy_len == 9'h080 || busy_len == 9'h100)
    else $error("busy spell of wrong length");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("register write not answered");
  c_path_back: cover property ($rose(port_memory_interface_enabled));
  c_flash_sum: cover property ($fell(busy) && busy_len == 9'h100);
  c_read: cover property (port_rvalid);
endmodule : encs_sequencer_assertions
bind encs_sequencer encs_sequencer_assertions u_chk (.aclk, .aresetn,
  .port_req_valid, .port_req, .port_req_ready, .port_rvalid,
  .port_memory_interface_enabled, .busy, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);

// File: verification/encs_programmer.sv
// external programmer model driving the debug port memory path
`timescale 1ns/1ps
module encs_programmer (
  // clock
  input wire logic aclk,
  // request side
  output logic port_req_valid,
  output encs_pkg::encs_port_req_t port_req,
  input wire logic port_req_ready,
  // answer side
  input wire logic port_rvalid,
  input wire logic [7:0] port_rdata,
  input wire logic port_memory_interface_enabled
);
  import encs_pkg::*;
  initial begin
    port_req_valid = 1'b0;
    port_req = '0;
  end
  // one port instruction; released lines show the inverse pattern
  task automatic xfer(input logic we, input logic [15:0] a,
    input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    @(posedge aclk);
    while (!port_memory_interface_enabled) @(posedge aclk);
    port_req_valid <= 1'b1;
    port_req <= '{we: we, addr: a, wdata: d};
    do @(posedge aclk); while (!port_req_ready);
    port_req_valid <= 1'b0;
    port_req <= ~port_req;
    if (!we) begin
      @(posedge aclk);
      q = port_rvalid ? port_rdata : 8'hxx;
    end
  endtask : xfer
endmodule : encs_programmer

// File: verification/tb_encs_sequencer.sv
// self-checking bench for the nvm command sequencer
`timescale 1ns/1ps
`include "encs_cfg.svh"
module tb_encs_sequencer;
  import encs_pkg::*;
  logic aclk, aresetn, busy, port_memory_interface_enabled, port_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, port_req_valid, port_req_ready;
  encs_port_req_t port_req;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] mirror [`ENCS_FLASH_BYTES];
  encs_sequencer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_req_valid,
    .port_req, .port_req_ready, .port_rvalid, .port_rdata,
    .port_memory_interface_enabled, .busy);
  encs_programmer prog (.aclk, .port_req_valid, .port_req,
    .port_req_ready, .port_rvalid, .port_rdata,
    .port_memory_interface_enabled);
  // 20 mhz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 0, w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, exp);
  endtask : rd_chk
  task automatic ld(input encs_cmd_t c);
    axi_wr(`ENCS_ADDR_CMD, {25'h0, c});
  endtask : ld
  task automatic run(input encs_cmd_t c);
    ld(c);
    axi_wr(`ENCS_ADDR_MEMORY_CONTROL_A, 32'h1);
  endtask : run
  task automatic pw(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    prog.xfer(1'b1, a, d, q);
  endtask : pw
  task automatic pr(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    prog.xfer(1'b0, a, 8'h00, q);
    chk({24'h0, q}, {24'h0, exp});
  endtask : pr
  // busy first, then idle
  task automatic wait_done;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`ENCS_ADDR_STATUS, d, r);
    chk(d[0], 1'b1);
    while (d[1:0] !== 2'b10) axi_rd(`ENCS_ADDR_STATUS, d, r);
  endtask : wait_done
  task automatic path_off;
    @(negedge aclk);
    chk({busy, port_memory_interface_enabled}, 2'b10);
    @(posedge aclk);
  endtask : path_off
  function automatic logic [15:0] crc16();
    logic [15:0] c;
    c = `ENCS_CRC_INIT;
    for (int i = 0; i < `ENCS_FLASH_BYTES; i++) begin
      c = c ^ {mirror[i], 8'h00};
      repeat (8) c = c[15] ? ((c << 1) ^ `ENCS_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc16
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(`ENCS_ADDR_STATUS, 32'h2);
    rd_chk(`ENCS_ADDR_CMD, 32'h0);
    axi_rd(8'h14, d, r);
    chk({30'h0, r}, 32'h2);
    chk(d, 32'h0);
  endtask : t_reset
  task automatic t_flash_page;
    ld(cmd_ld_fbuf);
    pw(16'h0010, 8'h34);
    pw(16'h0011, 8'h12);
    ld(cmd_ew_apage);
    pw(16'h0010, 8'h00);
    wait_done;
    pw(16'h0025, 8'h00);
    wait_done;
    ld(cmd_read);
    pr(16'h0010, 8'h34);
    pr(16'h0011, 8'h12);
    pr(16'h0012, 8'hff);
    ld(cmd_er_apage);
    pw(16'h0020, 8'h00);
    wait_done;
    ld(cmd_read);
    pr(16'h0020, 8'hff);
    pr(16'h0010, 8'h34);
    mirror[16] = 8'h34;
    mirror[17] = 8'h12;
  endtask : t_flash_page
  task automatic t_eeprom;
    ld(cmd_ld_ebuf);
    pw(16'h1000, 8'h5a);
    ld(cmd_wr_epage);
    pw(16'h1003, 8'h00);
    wait_done;
    ld(cmd_rd_eep);
    pr(16'h1000, 8'h5a);
    pr(16'h1001, 8'hff);
  endtask : t_eeprom
  task automatic t_fuse_lock;
    axi_wr(`ENCS_ADDR_DATA, 32'hf7);
    ld(cmd_wr_fuse);
    pw(16'h2005, 8'hf7);
    wait_done;
    axi_wr(`ENCS_ADDR_DATA, 32'hfb);
    pw(16'h2005, 8'hfb);
    wait_done;
    ld(cmd_rd_fuse);
    pr(16'h2005, 8'hf3);
    axi_wr(`ENCS_ADDR_DATA, 32'h0);
    ld(cmd_wr_fuse);
    pw(16'h2007, 8'h00);
    wait_done;
    rd_chk(`ENCS_ADDR_LOCK, 32'h0);
    ld(cmd_read);
    pr(16'h0010, 8'h00);
    rd_chk(`ENCS_ADDR_STATUS, 32'h6);
  endtask : t_fuse_lock
  task automatic t_crc;
    run(cmd_flash_crc);
    path_off;
    wait_done;
    rd_chk(`ENCS_ADDR_DATA, {16'h0, crc16()});
  endtask : t_crc
  task automatic t_chip_erase;
    run(cmd_chip_erase);
    path_off;
    wait_done;
    ld(cmd_read);
    pr(16'h0010, 8'hff);
    pr(16'h1000, 8'h5a);
    pr(16'h2005, 8'hf3);
    rd_chk(`ENCS_ADDR_LOCK, 32'hff);
  endtask : t_chip_erase
  task automatic t_section;
    run(cmd_er_eep);
    wait_done;
    ld(cmd_rd_eep);
    pr(16'h1000, 8'hff);
    ld(cmd_rd_cal);
    pr(16'h3103, 8'ha6);
    ld(cmd_rd_sig);
    pr(16'h3000, 8'hff);
  endtask : t_section
  // cut a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done;
  end
  // reset, then the scenarios in turn
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    s_axi_rready = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    foreach (mirror[i]) mirror[i] = 8'hff;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_flash_page;
    t_eeprom;
    t_fuse_lock;
    t_crc;
    t_chip_erase;
    t_section;
    test_done;
  end
endmodule : tb_encs_sequencer
